/* core/hang_params.svh */
`ifndef HANG_PARAMS_SVH
`define HANG_PARAMS_SVH

// Rate of the link clock that runs the pin engine, in kHz.
`define LINK_CLK_KHZ 20833

// Half period of a recovery clock pulse (100 kHz bus), least time.
`define SCL_HALF_NS 5000
`define SCL_HALF_CYC ((`SCL_HALF_NS * `LINK_CLK_KHZ + 999999) / 1000000)

// Data low with clock high for this long, while idle, means a hung bus.
`define HUNG_NS 10000
`define HUNG_CYC ((`HUNG_NS * `LINK_CLK_KHZ + 999999) / 1000000)

// Most recovery clock pulses in one bus-clear attempt.
`define MAX_PULSES 9

// System clocks that reset is stretched by, so the link clock sees it.
`define LINK_RST_CYC 64

// Idle level of both bus lines after filtering.
`define PIN_IDLE 2'b11

`endif

/* core/hang_pkg.sv */
package hang_pkg;

   // States of the bus-clear engine on the link clock.
   typedef enum logic [2:0]
   {
      LS_IDLE  = 3'b000,
      LS_LOW   = 3'b001,
      LS_HIGH  = 3'b010,
      LS_START = 3'b011,
      LS_STOP  = 3'b100,
      LS_FAIL  = 3'b101,
      LS_DONE  = 3'b110
   } link_state_t;

   // The two bus lines, carried together.
   typedef struct packed
   {
      logic scl;
      logic sda;
   } pins_t;

   // Status that the link side reports to the system side.
   typedef struct packed
   {
      logic hung;
      logic done_tgl;
      logic stuck;
   } link_stat_t;

endpackage

/* core/sync3.sv */
`timescale 1ns/1ps

// Three-stage synchroniser; the output moves once stages two and three
// agree, so a single metastable sample never reaches the user.
module sync3
#(
   parameter int         W   = 1,
   parameter logic [W-1:0] RST = '0
)
(
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   // Per-bit agreement of the last two stages.
   wire  [W-1:0] agree = ~(s2_r ^ s3_r);
   wire  [W-1:0] q_nxt = (agree & s3_r) | (~agree & q);

   // The shift chain and the filtered output.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         s1_r <= RST;
         s2_r <= RST;
         s3_r <= RST;
         q    <= RST;
      end
      else
      begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q    <= q_nxt;
      end
   end

endmodule

/* core/i2c_bus_clear.sv */
`timescale 1ns/1ps
`include "hang_params.svh"

module i2c_bus_clear
#(
   parameter int HALF_CYC   = `SCL_HALF_CYC,
   parameter int HUNG_CYC   = `HUNG_CYC,
   parameter int MAX_PULSES = `MAX_PULSES
)
(
   input  wire logic          clk,
   input  wire logic          reset_n,
   input  wire logic          link_clk,
   input  wire logic          recover_req,
   input  wire logic          err_clear,
   input  wire hang_pkg::pins_t pin_in,
   output hang_pkg::pins_t    pin_out,
   output hang_pkg::pins_t    pin_oe,
   output logic               xfer_grant,
   output logic               busy,
   output logic               bus_hung,
   output logic               stuck_err,
   output logic               recovered
);
   import hang_pkg::*;

   localparam logic [8:0] HALF_LIM = 9'(HALF_CYC);
   localparam logic [8:0] HUNG_LIM = 9'(HUNG_CYC);
   localparam logic [3:0] LAST_PULSE = 4'(MAX_PULSES - 1);
   localparam int         PULSE_CAP = MAX_PULSES;
   localparam logic [6:0] RST_HOLD = 7'(`LINK_RST_CYC);

   // True on the last cycle of a timed phase.
   function automatic logic expired(input logic [8:0] c,
                                    input logic [8:0] lim);
      expired = (c == lim - 9'h001);
   endfunction

   // Reset is stretched on clk so that the slower link clock surely sees
   // it; the link-domain reset is a synchronous copy of the stretched one.
   logic [6:0] rst_cnt_r;
   logic       rst_l1_r;
   logic       rst_l2_r;
   logic       link_rst_n;
   wire        sys_rst_n = reset_n && rst_cnt_r == RST_HOLD;

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         rst_cnt_r <= 7'h00;
      else if (rst_cnt_r != RST_HOLD)
         rst_cnt_r <= rst_cnt_r + 7'h01;
   end

   always_ff @(posedge link_clk)
   begin
      rst_l1_r   <= sys_rst_n;
      rst_l2_r   <= rst_l1_r;
      link_rst_n <= rst_l2_r;
   end

   // System-side registers.
   logic       req_tgl_r;
   logic       done_prev_r;
   link_stat_t stat_s;

   // Link-side registers.
   link_state_t state_r;
   link_state_t state_nxt;
   logic [8:0]  timer_r;
   logic [8:0]  hold_r;
   logic [3:0]  pulses_r;
   logic [3:0]  pulses_nxt;
   logic        hung_r;
   logic        done_tgl_r;
   logic        stuck_r;
   logic        stuck_nxt;
   logic        req_prev_r;
   logic        req_s;
   pins_t       pin_f;
   pins_t       oe_r;
   pins_t       out_r;

   // Bus lines are filtered on the link clock before use.
   sync3 #(.W(2), .RST(`PIN_IDLE)) u_pin_sync
   (
      .clk     (link_clk),
      .reset_n (link_rst_n),
      .d       (pin_in),
      .q       (pin_f)
   );

   // The request toggle crosses into the link domain.
   sync3 #(.W(1), .RST(1'b0)) u_req_sync
   (
      .clk     (link_clk),
      .reset_n (link_rst_n),
      .d       (req_tgl_r),
      .q       (req_s)
   );

   // Status crosses back; stuck settles a cycle before done toggles.
   link_stat_t stat_l;
   assign stat_l = '{hung: hung_r, done_tgl: done_tgl_r, stuck: stuck_r};

   sync3 #(.W(3), .RST(3'b000)) u_stat_sync
   (
      .clk     (clk),
      .reset_n (sys_rst_n),
      .d       (stat_l),
      .q       (stat_s)
   );

   // Link-side decoding of the bus and the phase timers.
   wire go        = req_s != req_prev_r;
   wire half_done = expired(timer_r, HALF_LIM);
   wire stuck_lvl = !pin_f.sda && pin_f.scl;
   wire idle      = state_r == LS_IDLE;
   wire hung_nxt  = idle && stuck_lvl && expired(hold_r, HUNG_LIM);
   wire hold_keep = hung_nxt || !stuck_lvl || !idle;
   wire [8:0] hold_nxt = hold_keep ? (hung_nxt ? hold_r : 9'h000)
                                   : hold_r + 9'h001;
   // The high phase only counts once the clock is really high.
   wire stretch   = state_r == LS_HIGH && !pin_f.scl;
   wire [8:0] timer_nxt = (state_nxt != state_r || stretch) ? 9'h000
                                                           : timer_r + 9'h001;

   // Next state of the bus-clear engine.
   always_comb
   begin
      state_nxt  = state_r;
      pulses_nxt = pulses_r;
      stuck_nxt  = stuck_r;
      case (state_r)
         LS_IDLE:
         begin
            if (go)
            begin
               state_nxt  = LS_LOW;
               pulses_nxt = 4'h0;
               stuck_nxt  = 1'b0;
            end
         end
         LS_LOW:
         begin
            if (half_done)
               state_nxt = LS_HIGH;
         end
         LS_HIGH:
         begin
            if (half_done)
            begin
               pulses_nxt = pulses_r + 4'h1;
               if (pin_f.sda)
                  state_nxt = LS_START;
               else if (pulses_r == LAST_PULSE)
                  state_nxt = LS_FAIL;
               else
                  state_nxt = LS_LOW;
            end
         end
         LS_START:
         begin
            if (half_done)
               state_nxt = LS_STOP;
         end
         LS_STOP:
         begin
            if (half_done)
               state_nxt = LS_DONE;
         end
         LS_FAIL:
         begin
            stuck_nxt = 1'b1;
            state_nxt = LS_DONE;
         end
         LS_DONE:
            state_nxt = LS_IDLE;
         default:
            state_nxt = LS_IDLE;
      endcase
   end

   // Pin drive follows the state: clock low in the low phase, data low
   // for the start condition; the stop is the release that follows.
   pins_t oe_nxt;
   assign oe_nxt = '{scl: state_nxt == LS_LOW, sda: state_nxt == LS_START};

   // Link-side state registers.
   always_ff @(posedge link_clk)
   begin
      if (!link_rst_n)
      begin
         state_r    <= LS_IDLE;
         timer_r    <= 9'h000;
         hold_r     <= 9'h000;
         pulses_r   <= 4'h0;
         hung_r     <= 1'b0;
         stuck_r    <= 1'b0;
         req_prev_r <= 1'b0;
         oe_r       <= 2'b00;
         out_r      <= 2'b00;
      end
      else
      begin
         state_r    <= state_nxt;
         timer_r    <= timer_nxt;
         hold_r     <= hold_nxt;
         pulses_r   <= pulses_nxt;
         hung_r     <= hung_nxt;
         stuck_r    <= stuck_nxt;
         req_prev_r <= req_s;
         oe_r       <= oe_nxt;
         out_r      <= 2'b00;
      end
   end

   // Completion toggle, kept apart so it flips after stuck has settled.
   always_ff @(posedge link_clk)
   begin
      if (!link_rst_n)
         done_tgl_r <= 1'b0;
      else if (state_r == LS_DONE)
         done_tgl_r <= !done_tgl_r;
   end

   assign pin_oe  = oe_r;
   assign pin_out = out_r;

   // System-side decoding: launch, completion and flags.
   logic busy_r;
   logic stuck_err_r;
   logic hung_c_r;
   logic grant_r;
   logic rec_r;

   wire done_evt  = stat_s.done_tgl != done_prev_r;
   wire auto_go   = stat_s.hung && !stuck_err_r;
   wire launch    = !busy_r && (recover_req || auto_go);
   wire busy_nxt  = launch || (busy_r && !done_evt);
   wire err_set   = done_evt && stat_s.stuck;
   wire err_nxt   = err_set || (stuck_err_r && !err_clear);
   wire grant_nxt = !busy_nxt && !stat_s.hung;

   // System-side registers; a failure set beats a clear in one cycle.
   always_ff @(posedge clk)
   begin
      if (!sys_rst_n)
      begin
         req_tgl_r   <= 1'b0;
         done_prev_r <= 1'b0;
         busy_r      <= 1'b0;
         stuck_err_r <= 1'b0;
         hung_c_r    <= 1'b0;
         grant_r     <= 1'b0;
         rec_r       <= 1'b0;
      end
      else
      begin
         req_tgl_r   <= req_tgl_r ^ launch;
         done_prev_r <= stat_s.done_tgl;
         busy_r      <= busy_nxt;
         stuck_err_r <= err_nxt;
         hung_c_r    <= stat_s.hung;
         grant_r     <= grant_nxt;
         rec_r       <= done_evt && !stat_s.stuck;
      end
   end

   assign busy       = busy_r;
   assign stuck_err  = stuck_err_r;
   assign bus_hung   = hung_c_r;
   assign xfer_grant = grant_r;
   assign recovered  = rec_r;

   // Checks on the system clock.
   a_grant_blocked: assert property
      (@(posedge clk) disable iff (!reset_n)
       (bus_hung || busy) |-> !xfer_grant)
      else $error("grant given while bus hung or busy");

   a_hung_launch: assert property
      (@(posedge clk) disable iff (!reset_n)
       (stat_s.hung && !busy_r && !stuck_err_r) |=> busy_r)
      else $error("hung bus did not start recovery");

   a_error_sticky: assert property
      (@(posedge clk) disable iff (!reset_n)
       (stuck_err && !err_clear) |=> stuck_err)
      else $error("bus-stuck flag lost without clear");

   // Checks on the link clock.
   a_pulse_limit: assert property
      (@(posedge link_clk) disable iff (!link_rst_n)
       $rose(oe_r.scl) |-> pulses_r < PULSE_CAP)
      else $error("more than the allowed recovery pulses");

   a_one_at_time: assert property
      (@(posedge link_clk) disable iff (!link_rst_n)
       $fell(oe_r.scl) |=> !oe_r.scl [*2])
      else $error("recovery pulse high phase too short");

   a_sample_high: assert property
      (@(posedge link_clk) disable iff (!link_rst_n)
       (state_r == LS_HIGH && state_nxt != LS_HIGH) |-> pin_f.scl)
      else $error("data sampled while clock not high");

   a_stop_released: assert property
      (@(posedge link_clk) disable iff (!link_rst_n)
       (state_r == LS_HIGH && half_done && pin_f.sda)
       |=> state_r == LS_START ##1 !oe_r.scl)
      else $error("pulses continued after data went high");

   a_start_shape: assert property
      (@(posedge link_clk) disable iff (!link_rst_n)
       $rose(oe_r.sda) |-> !oe_r.scl)
      else $error("start driven with clock held low");

   a_fail_flag: assert property
      (@(posedge link_clk) disable iff (!link_rst_n)
       (state_r == LS_FAIL) |=> stuck_r ##1 state_r == LS_IDLE)
      else $error("failed recovery did not flag stuck");

   // Main scenarios.
   c_recovered: cover property
      (@(posedge clk) disable iff (!reset_n) $rose(recovered));
   c_stuck: cover property
      (@(posedge clk) disable iff (!reset_n) $rose(stuck_err));
   c_start_sent: cover property
      (@(posedge link_clk) disable iff (!link_rst_n)
       state_r == LS_START);

endmodule

/* tb/stuck_slave.sv */
`timescale 1ns/1ps

// Slave left behind by a master reset in mid-read. Once armed it pulls the
// data line low and only lets go after it has seen lim clock rises, since
// nothing else moves its shift state along.
module stuck_slave
(
   input  wire logic       arm,
   input  wire logic [3:0] lim,
   input  wire logic       scl,
   output logic            sda_oe
);
   logic [3:0] cnt_r = 4'h0;
   logic [3:0] base_r = 4'h0;
   logic [3:0] seen;

   // Every clock rise counts; arming notes where the count stood.
   always @(posedge scl) cnt_r <= cnt_r + 4'h1;
   always @(posedge arm) base_r <= cnt_r;

   // Data stays low until the needed number of clock rises has passed.
   assign seen   = cnt_r - base_r;
   assign sda_oe = arm && (seen < lim);
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
   import hang_pkg::*;
   logic       clk = 1'h0;
   logic       link_clk = 1'h0;
   logic       reset_n = 1'h0;
   logic       recover_req = 1'h0;
   logic       err_clear = 1'h0;
   logic       arm = 1'h0;
   logic [3:0] lim = 4'h0;
   pins_t      pin_in_w;
   pins_t      pin_out_w;
   pins_t      pin_oe_w;
   logic       xfer_grant;
   logic       busy;
   logic       bus_hung;
   logic       stuck_err;
   logic       recovered;
   logic       sda_oe;
   int         fails = 0;
   int         n_checks = 0;
   int         cyc = 0;
   int         n_pul = 0;
   int         n_sta = 0;
   int         n_rec = 0;

   // System clock, and a link clock with an odd start offset.
   initial forever #2.5 clk = ~clk;
   initial
   begin
      #7;
      forever #24 link_clk = ~link_clk;
   end

   // Open-drain bus with pull-ups: any enabled party pulls a line low.
   assign pin_in_w = {~pin_oe_w.scl, ~(pin_oe_w.sda | sda_oe)};

   i2c_bus_clear #(.HALF_CYC(8), .HUNG_CYC(16), .MAX_PULSES(9)) dut
   (
      .clk         (clk),
      .reset_n     (reset_n),
      .link_clk    (link_clk),
      .recover_req (recover_req),
      .err_clear   (err_clear),
      .pin_in      (pin_in_w),
      .pin_out     (pin_out_w),
      .pin_oe      (pin_oe_w),
      .xfer_grant  (xfer_grant),
      .busy        (busy),
      .bus_hung    (bus_hung),
      .stuck_err   (stuck_err),
      .recovered   (recovered)
   );

   stuck_slave slave
   (
      .arm    (arm),
      .lim    (lim),
      .scl    (pin_in_w.scl),
      .sda_oe (sda_oe)
   );

   // Recovery pulses and start conditions are counted on the wire.
   always @(posedge pin_oe_w.scl) n_pul++;
   always @(posedge pin_oe_w.sda) n_sta++;

   // Settled outputs are watched on the falling edge; a hang is cut short.
   always @(negedge clk)
   begin
      cyc++;
      if (recovered === 1'h1) n_rec++;
      if (bus_hung === 1'h1) chk("grant hung", 8'h0, {7'h0, xfer_grant});
      chk("pin out", 8'h0, {6'h0, pin_out_w});
      if (cyc == 60000)
      begin
         fails++;
         stop_test();
      end
   end

   task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value %s: expected %0h, seen %0h", name, exp, got);
      end
   endtask

   task stop_test;
      if (fails == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task wait_busy(input logic v);
      int i;
      i = 0;
      while (busy !== v && i < 5000)
      begin
         @(negedge clk);
         i++;
      end
   endtask

   // Pulses expected: one for a clean bus, else until release, nine at most.
   function automatic int exp_pul(input int k, input logic man);
      return man ? 1 : (k > 9 ? 9 : k);
   endfunction

   // One bus-clear, either asked for or launched by a hung slave.
   task run(input logic [3:0] k, input logic man);
      int   p0;
      int   s0;
      int   r0;
      logic ok;
      p0 = n_pul;
      s0 = n_sta;
      r0 = n_rec;
      ok = man || k <= 4'h9;
      @(posedge clk);
      recover_req <= man;
      arm <= !man;
      lim <= k;
      @(posedge clk);
      recover_req <= 1'h0;
      wait_busy(1'h1);
      chk("grant busy", 8'h0, {7'h0, xfer_grant});
      chk("hung", {7'h0, !man}, {7'h0, bus_hung});
      @(posedge clk);
      recover_req <= man;
      @(posedge clk);
      recover_req <= 1'h0;
      wait_busy(1'h0);
      repeat (2) @(negedge clk);
      chk("start", {7'h0, ok}, 8'(n_sta - s0));
      chk("recovered", {7'h0, ok}, 8'(n_rec - r0));
      chk("stuck", {7'h0, !ok}, {7'h0, stuck_err});
      @(posedge clk);
      arm <= 1'h0;
      if (!ok)
      begin
         repeat (200) @(posedge clk);
         chk("stuck held", 8'h1, {7'h0, stuck_err});
         err_clear <= 1'h1;
         @(posedge clk);
         err_clear <= 1'h0;
      end
      repeat (300) @(negedge clk);
      chk("pulses", 8'(exp_pul(k, man)), 8'(n_pul - p0));
      chk("grant idle", 8'h1, {7'h0, xfer_grant});
   endtask

   // Reset, a clean request, corner release counts, then random ones.
   initial
   begin
      int k;
      void'($urandom(32'hF63D));
      repeat (5) @(posedge clk);
      reset_n <= 1'h1;
      repeat (120) @(posedge clk);
      chk("grant reset", 8'h1, {7'h0, xfer_grant});
      run(4'h0, 1'h1);
      run(4'h1, 1'h0);
      run(4'h9, 1'h0);
      run(4'hF, 1'h0);
      repeat (5)
      begin
         k = 1 + $urandom % 9;
         run(k[3:0], 1'h0);
      end
      stop_test();
   end
endmodule
